/* rtl/phy_basic_control_regs.sv */
`timescale 1ns/1ns
// Overview of operation
// - Ports 1-4 answer PHY addresses 0x1-0x4.
// - Decode registers 0x0-0x5, 0x1D, 0x1F only.
// - Only the basic control register is reachable over SPI port.
// - SPI uses its own address mapping.
// - Bit 15 soft reset, self-clearing, resets 0.
// - Bit 14 MAC-side loopback per port.
// - Bit 13 forced speed, 1=100M, reset 1.
// - Bit 12 autonegotiation enable, reset 1.
// - Bit 11 power-down, reset 0.
// - Bit 10 isolates transmitter from pair.
// - Bit 9 restarts autonegotiation, self-clearing.
// - Bit 8 forced duplex, 1=full, reset 1.
// - Bit 5 crossover algorithm select, reset 1.
// - Bit 4 forces straight wiring when detect off.
// - Bit 3 disables crossover detection, reset 0.
// - Bit 2 disables far-end fault detection.
// - Bit 1 disables transmitter, reset 0.
// - Bit 0 turns indicators off, reset 0.
module phy_basic_control_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Management (MIIM) access, one-cycle request
   input phy_ctrl_pkg::miim_req_s miim_req,
   output logic miim_ack,
   output logic miim_hit,
   output logic [15:0] miim_rdata,
   // SPI byte access, one-cycle request
   input phy_ctrl_pkg::spi_req_s spi_req,
   output logic spi_ack,
   output logic [7:0] spi_rdata,
   // Per-port controls
   output phy_ctrl_pkg::port_ctrl_s port_ctrl [phy_ctrl_pkg::NUM_PORTS],
   output logic [phy_ctrl_pkg::NUM_PORTS-1:0] mdi_straight
);
   import phy_ctrl_pkg::*;

   // ---------------------------------------------------------------
   // Reset release
   // ---------------------------------------------------------------
   logic rst_meta_ff;
   logic rst_sync_ff;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   logic miim_port_ok;
   logic [1:0] miim_port;
   logic miim_reg_ok;
   logic miim_ctrl_sel;
   logic [4:0] phy_ofs;

   assign phy_ofs = miim_req.phy_addr - PHYAD_FIRST;
   assign miim_port_ok = (miim_req.phy_addr >= PHYAD_FIRST) &&
      (miim_req.phy_addr <= PHYAD_LAST);
   assign miim_port = phy_ofs[1:0];
   assign miim_reg_ok = (miim_req.reg_addr <= REG_DECODE_LAST) ||
      (miim_req.reg_addr == REG_EXTRA_A) ||
      (miim_req.reg_addr == REG_EXTRA_B);
   assign miim_ctrl_sel = miim_port_ok &&
      (miim_req.reg_addr == REG_BASIC_CONTROL);

   // SPI: port n control at base + (n-1)*stride, high byte first
   logic spi_port_ok;
   logic [1:0] spi_port;
   logic spi_is_hi;
   logic spi_is_lo;
   logic [7:0] spi_rel;

   assign spi_rel = spi_req.addr - SPI_CTRL_BASE;
   assign spi_port = spi_rel[5:4];
   assign spi_port_ok = (spi_req.addr >= SPI_CTRL_BASE) &&
      (spi_rel < 8'(NUM_PORTS * SPI_PORT_STRIDE));
   assign spi_is_hi = spi_port_ok && (spi_rel[3:0] == SPI_CTRL_HI_OFS[3:0]);
   assign spi_is_lo = spi_port_ok && (spi_rel[3:0] == SPI_CTRL_LO_OFS[3:0]);

   // Handshake answers in the request cycle
   assign miim_ack = miim_req.valid;
   assign spi_ack = spi_req.valid;

   // ---------------------------------------------------------------
   // Control registers, one per port
   // ---------------------------------------------------------------
   logic [15:0] ctrl_ff [NUM_PORTS];
   logic [15:0] pulse_ff [NUM_PORTS];

   genvar p;
   generate
      for (p = 0; p < NUM_PORTS; p++) begin : g_port
         logic miim_wr;
         logic spi_wr_hi;
         logic spi_wr_lo;
         logic [15:0] wr_word;
         logic wr_any;
         logic [15:0] nxt_ctrl;

         assign miim_wr = miim_req.valid && miim_req.write &&
            miim_ctrl_sel && (miim_port == 2'(p));
         assign spi_wr_hi = spi_req.valid && spi_req.write && spi_is_hi &&
            (spi_port == 2'(p));
         assign spi_wr_lo = spi_req.valid && spi_req.write && spi_is_lo &&
            (spi_port == 2'(p));
         assign wr_any = miim_wr || spi_wr_hi || spi_wr_lo;

         // Byte writes merge with the stored half
         always_comb begin
            wr_word = ctrl_ff[p];
            if (miim_wr) begin
               wr_word = miim_req.wdata;
            end else if (spi_wr_hi) begin
               wr_word = {spi_req.wdata, ctrl_ff[p][7:0]};
            end else if (spi_wr_lo) begin
               wr_word = {ctrl_ff[p][15:8], spi_req.wdata};
            end
         end

         // Reserved bits never store; self-clearing bits never store
         assign nxt_ctrl = wr_word & CTRL_STORE_MASK;

         always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
               ctrl_ff[p] <= CTRL_RESET;
            end else if (wr_any) begin
               ctrl_ff[p] <= nxt_ctrl;
            end
         end

         // Soft reset and restart are one-cycle pulses, then clear
         always_ff @(posedge clk or negedge rst_sync_ff) begin
            if (!rst_sync_ff) begin
               pulse_ff[p] <= '0;
            end else if (wr_any) begin
               pulse_ff[p] <= wr_word & CTRL_PULSE_MASK;
            end else begin
               pulse_ff[p] <= '0;
            end
         end

         always_comb begin
            port_ctrl[p].soft_reset = pulse_ff[p][BIT_SOFT_RESET];
            port_ctrl[p].mac_loopback = ctrl_ff[p][BIT_LOOPBACK];
            port_ctrl[p].speed_100 = ctrl_ff[p][BIT_SPEED_100];
            port_ctrl[p].autoneg_on = ctrl_ff[p][BIT_AUTONEG_ON];
            port_ctrl[p].power_down = ctrl_ff[p][BIT_POWER_DOWN];
            port_ctrl[p].transceiver_isolation =
               ctrl_ff[p][BIT_ISOLATION];
            port_ctrl[p].autoneg_restart =
               pulse_ff[p][BIT_AUTONEG_RESTART];
            port_ctrl[p].full_duplex = ctrl_ff[p][BIT_FULL_DUPLEX];
            port_ctrl[p].crossover_algorithm_select =
               ctrl_ff[p][BIT_XOVER_ALG];
            port_ctrl[p].forced_straight_wiring =
               ctrl_ff[p][BIT_FORCED_STRAIGHT];
            port_ctrl[p].crossover_detect_off =
               ctrl_ff[p][BIT_XOVER_DETECT_OFF];
            port_ctrl[p].far_end_fault_off = ctrl_ff[p][BIT_FEF_OFF];
            port_ctrl[p].transmit_off = ctrl_ff[p][BIT_TX_OFF];
            port_ctrl[p].indicator_off =
               ctrl_ff[p][BIT_INDICATOR_OFF];
         end

         // Forced wiring only matters with detection off
         assign mdi_straight[p] = ctrl_ff[p][BIT_XOVER_DETECT_OFF] &&
            ctrl_ff[p][BIT_FORCED_STRAIGHT];
      end
   endgenerate

   // ---------------------------------------------------------------
   // Read data, registered
   // ---------------------------------------------------------------
   logic [15:0] miim_rdata_ff;
   logic miim_hit_ff;
   logic [7:0] spi_rdata_ff;
   logic [15:0] spi_word;

   assign spi_word = ctrl_ff[spi_port];

   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         miim_rdata_ff <= '0;
         miim_hit_ff <= 1'b0;
      end else if (miim_req.valid) begin
         miim_hit_ff <= miim_port_ok && miim_reg_ok;
         // Other decoded registers live outside this block, read zero
         miim_rdata_ff <= miim_ctrl_sel ? ctrl_ff[miim_port] : '0;
      end
   end

   always_ff @(posedge clk or negedge rst_sync_ff) begin
      if (!rst_sync_ff) begin
         spi_rdata_ff <= '0;
      end else if (spi_req.valid) begin
         if (spi_is_hi) begin
            spi_rdata_ff <= spi_word[15:8];
         end else if (spi_is_lo) begin
            spi_rdata_ff <= spi_word[7:0];
         end else begin
            spi_rdata_ff <= '0;
         end
      end
   end

   assign miim_rdata = miim_rdata_ff;
   assign miim_hit = miim_hit_ff;
   assign spi_rdata = spi_rdata_ff;
endmodule

/* rtl/phy_ctrl_pkg.sv */
package phy_ctrl_pkg;
   // ---------------------------------------------------------------
   // Addressing
   // ---------------------------------------------------------------
   localparam int NUM_PORTS = 4;
   localparam logic [4:0] PHYAD_FIRST = 5'h01;
   localparam logic [4:0] PHYAD_LAST = 5'h04;
   localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
   localparam logic [4:0] REG_DECODE_LAST = 5'h05;
   localparam logic [4:0] REG_EXTRA_A = 5'h1d;
   localparam logic [4:0] REG_EXTRA_B = 5'h1f;
   // SPI byte map: port n control word at SPI_BASE + (n-1)*SPI_STRIDE
   localparam logic [7:0] SPI_CTRL_BASE = 8'h10;
   localparam logic [7:0] SPI_PORT_STRIDE = 8'h10;
   localparam logic [7:0] SPI_CTRL_HI_OFS = 8'h00;
   localparam logic [7:0] SPI_CTRL_LO_OFS = 8'h01;
   // ---------------------------------------------------------------
   // Basic control field positions
   // ---------------------------------------------------------------
   localparam int BIT_SOFT_RESET = 15;
   localparam int BIT_LOOPBACK = 14;
   localparam int BIT_SPEED_100 = 13;
   localparam int BIT_AUTONEG_ON = 12;
   localparam int BIT_POWER_DOWN = 11;
   localparam int BIT_ISOLATION = 10;
   localparam int BIT_AUTONEG_RESTART = 9;
   localparam int BIT_FULL_DUPLEX = 8;
   localparam int BIT_XOVER_ALG = 5;
   localparam int BIT_FORCED_STRAIGHT = 4;
   localparam int BIT_XOVER_DETECT_OFF = 3;
   localparam int BIT_FEF_OFF = 2;
   localparam int BIT_TX_OFF = 1;
   localparam int BIT_INDICATOR_OFF = 0;
   localparam logic [15:0] CTRL_RESET = 16'h3120;
   // Bits that store a value; 15 and 9 self-clear, 7:6 reserved
   localparam logic [15:0] CTRL_STORE_MASK = 16'h7d3f;
   localparam logic [15:0] CTRL_PULSE_MASK = 16'h8200;

   // Per-port controls presented to the PHY and MAC
   typedef struct packed {
      logic soft_reset;
      logic mac_loopback;
      logic speed_100;
      logic autoneg_on;
      logic power_down;
      logic transceiver_isolation;
      logic autoneg_restart;
      logic full_duplex;
      logic crossover_algorithm_select;
      logic forced_straight_wiring;
      logic crossover_detect_off;
      logic far_end_fault_off;
      logic transmit_off;
      logic indicator_off;
   } port_ctrl_s;

   // Management access request (MIIM only; SPI uses spi_req_s below)
   typedef struct packed {
      logic valid;
      logic write;
      logic [4:0] phy_addr;
      logic [4:0] reg_addr;
      logic [15:0] wdata;
   } miim_req_s;

   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [7:0] wdata;
   } spi_req_s;
endpackage

/* verif/mgmt_master.sv */
`timescale 1ns/1ns
module mgmt_master (
   // Requests toward the control block
   output phy_ctrl_pkg::miim_req_s miim_req,
   output phy_ctrl_pkg::spi_req_s spi_req
);
   import phy_ctrl_pkg::*;
   initial begin
      miim_req = '0;
      spi_req = '0;
   end
   // Called just after a falling edge; an idle bus shows its stale fields inverted
   task automatic miim(input logic w, input logic [4:0] pa, ra,
         input logic [15:0] d);
      miim_req = {1'b1, w, pa, ra, d};
      spi_req = {1'b0, ~spi_req[16:0]};
   endtask
   task automatic spi(input logic w, input logic [7:0] a, d);
      spi_req = {1'b1, w, a, d};
      miim_req = {1'b0, ~miim_req[26:0]};
   endtask
   task automatic idle();
      miim_req = {1'b0, ~miim_req[26:0]};
      spi_req = {1'b0, ~spi_req[16:0]};
   endtask
endmodule

/* verif/phy_ctrl_checker.sv */
`timescale 1ns/1ns
module phy_ctrl_checker (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Access ports
   input phy_ctrl_pkg::miim_req_s miim_req,
   input wire logic miim_ack,
   input wire logic miim_hit,
   input wire logic [15:0] miim_rdata,
   input phy_ctrl_pkg::spi_req_s spi_req,
   input wire logic spi_ack,
   input wire logic [7:0] spi_rdata,
   // Port controls
   input phy_ctrl_pkg::port_ctrl_s port_ctrl [phy_ctrl_pkg::NUM_PORTS],
   input wire logic [phy_ctrl_pkg::NUM_PORTS-1:0] mdi_straight
);
   import phy_ctrl_pkg::*;
   logic ok, dec, w0, pq;
   logic [11:0] lvl;
   assign ok = miim_req.phy_addr inside {[PHYAD_FIRST:PHYAD_LAST]};
   assign dec = miim_req.reg_addr inside {[5'h00:5'h05], 5'h1d, 5'h1f};
   assign w0 = miim_req.valid && miim_req.write
      && miim_req.phy_addr == 5'h01 && miim_req.reg_addr == 5'h00;
   // Either bus may raise a pulse; MIIM priority is not modelled here
   assign pq = (w0 && (miim_req.wdata & CTRL_PULSE_MASK) != 16'h0000)
      || (spi_req.valid && spi_req.write && spi_req.addr == 8'h10
      && (spi_req.wdata & 8'h82) != 8'h00);
   assign lvl = {miim_req.wdata[14:10], miim_req.wdata[8],
      miim_req.wdata[5:0]};
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   ack_echo_a: assert property (miim_ack == miim_req.valid
      && spi_ack == spi_req.valid) else $error("ack not valid echo");
   phy_miss_a: assert property (
      miim_req.valid && !ok |=> !miim_hit && miim_rdata == 16'h0000)
      else $error("foreign phy address answered");
   reg_hit_a: assert property (
      miim_req.valid |=> miim_hit == $past(ok && dec))
      else $error("register decode wrong");
   other_zero_a: assert property (
      miim_req.valid && miim_req.reg_addr != 5'h00 |=> miim_rdata == 0)
      else $error("other register not zero");
   spi_miss_a: assert property (
      spi_req.valid && !(spi_req.addr inside {8'h10, 8'h11, 8'h20,
      8'h21, 8'h30, 8'h31, 8'h40, 8'h41}) |=> spi_rdata == 8'h00)
      else $error("unmapped byte not zero");
   pulse_src_a: assert property (
      port_ctrl[0].soft_reset || port_ctrl[0].autoneg_restart |-> $past(pq))
      else $error("pulse without a write");
   stored_a: assert property (
      w0 |=> {port_ctrl[0][12:8], port_ctrl[0][6:0]} == $past(lvl)
      && port_ctrl[0].soft_reset == $past(miim_req.wdata[15]))
      else $error("written word not applied");
   hold_a: assert property (!miim_req.valid |=> $stable(miim_rdata)
      && $stable(miim_hit)) else $error("read data not held");
   mdi_a: assert property (mdi_straight[0] ==
      (port_ctrl[0].crossover_detect_off
      && port_ctrl[0].forced_straight_wiring)) else $error("wiring wrong");
   soft_c: cover property (w0 && miim_req.wdata[15]);
   spi_c: cover property (spi_req.valid && spi_req.write);
   miss_c: cover property (miim_req.valid && !ok);
endmodule

/* verif/tb_top.sv */
`timescale 1ns/1ns
module tb_top;
   import phy_ctrl_pkg::*;
   logic clk, rst_b, miim_ack, miim_hit, spi_ack;
   miim_req_s miim_req;
   spi_req_s spi_req;
   logic [15:0] miim_rdata;
   logic [7:0] spi_rdata;
   logic [31:0] r;
   port_ctrl_s port_ctrl [NUM_PORTS];
   logic [NUM_PORTS-1:0] mdi_straight;
   logic [15:0] word [NUM_PORTS];
   logic [15:0] pls [NUM_PORTS];
   int error_cnt, checked, seed;
   mgmt_master mst (.miim_req(miim_req), .spi_req(spi_req));
   phy_basic_control_regs DUT (.clk(clk), .rst_b(rst_b),
      .miim_req(miim_req), .miim_ack(miim_ack), .miim_hit(miim_hit),
      .miim_rdata(miim_rdata), .spi_req(spi_req), .spi_ack(spi_ack),
      .spi_rdata(spi_rdata), .port_ctrl(port_ctrl),
      .mdi_straight(mdi_straight));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic cmp(input logic [15:0] got, exp);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checked %0d error_cnt %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic chk_ports();
      logic [15:0] w;
      for (int i = 0; i < NUM_PORTS; i++) begin
         w = word[i] | pls[i];
         cmp({2'b00, port_ctrl[i]}, {2'b00, w[15:8], w[5:0]});
         cmp({15'h0, mdi_straight[i]}, {15'h0, w[3] & w[4]});
         pls[i] = 16'h0000;
      end
   endtask
   task automatic m_op(input logic w, input logic [4:0] pa, ra,
         input logic [15:0] d);
      logic ok;
      logic [15:0] e;
      ok = pa inside {[5'h01:5'h04]};
      e = (ok && ra == 5'h00) ? word[pa-1] : 16'h0000;
      mst.miim(w, pa, ra, d);
      if (ok && ra == 5'h00 && w) begin
         word[pa-1] = d & 16'h7d3f;
         pls[pa-1] = d & 16'h8200;
      end
      @(negedge clk);
      cmp(miim_hit, ok && ra inside {[0:5], 5'h1d, 5'h1f});
      if (!w) cmp(miim_rdata, e);
      chk_ports();
   endtask
   task automatic s_op(input logic w, input logic [7:0] a, d);
      logic [15:0] e;
      int p;
      p = a[7:4] - 1;
      e = 16'h0000;
      mst.spi(w, a, d);
      if (a[7:4] inside {[1:4]} && a[3:1] == 3'h0) begin
         e = a[0] ? word[p][7:0] : word[p][15:8];
         if (w && a[0]) word[p][7:0] = d & 8'h3f;
         if (w && !a[0]) word[p][15:8] = d & 8'h7d;
         if (w && !a[0]) pls[p][15:8] = d & 8'h82;
      end
      @(negedge clk);
      if (!w) cmp(spi_rdata, e);
      chk_ports();
   endtask
   initial begin
      seed = 32'he613;
      error_cnt = 0;
      checked = 0;
      rst_b = 1'b0;
      for (int i = 0; i < NUM_PORTS; i++) begin
         word[i] = 16'h3120;
         pls[i] = 16'h0000;
      end
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 0; i < 8; i++) m_op(1'b0, 5'(i), 5'h00, 16'h0000);
      for (int i = 1; i < 5; i++) begin
         m_op(1'b1, 5'(i), 5'h00, 16'hffff);
         m_op(1'b0, 5'(i), 5'h1f, 16'h0000);
         m_op(1'b0, 5'(i), 5'h00, 16'h0000);
         s_op(1'b0, 8'(i * 16), 8'h00);
      end
      for (int b = 0; b < 16; b++) begin
         m_op(1'b1, 5'h02, 5'h00, 16'h0001 << b);
         s_op(1'b1, 8'h31, 8'h18);
         s_op(1'b0, 8'h21, 8'h00);
      end
      m_op(1'b1, 5'h01, 5'h1e, 16'h0000);
      s_op(1'b1, 8'h12, 8'hff);
      // Mid-run reset with the bus idle; words return to reset value
      mst.idle();
      rst_b = 1'b0;
      @(negedge clk);
      for (int i = 0; i < NUM_PORTS; i++) word[i] = 16'h3120;
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      for (int i = 1; i < 5; i++) m_op(1'b0, 5'(i), 5'h00, 16'h0000);
      repeat (300) begin
         r = $random(seed);
         if (r[0]) m_op(r[1], {2'b00, r[4:2]}, r[5] ? 5'h00 : r[10:6],
            r[31:16]);
         else s_op(r[1], {1'b0, r[4:2], 2'b00, r[6:5]}, r[15:8]);
      end
      mst.idle();
      @(negedge clk);
      end_sim();
   end
   initial begin
      #200000;
      error_cnt++;
      end_sim();
   end
endmodule
bind phy_basic_control_regs phy_ctrl_checker chk (.clk(clk),
   .rst_b(rst_b), .miim_req(miim_req), .miim_ack(miim_ack),
   .miim_hit(miim_hit), .miim_rdata(miim_rdata), .spi_req(spi_req),
   .spi_ack(spi_ack), .spi_rdata(spi_rdata), .port_ctrl(port_ctrl),
   .mdi_straight(mdi_straight));
